// File: src/odsl_consts.vh
`ifndef ODSL_CONSTS_VH
`define ODSL_CONSTS_VH
`define ODSL_WORD_BITS 16
`define ODSL_CNT_BITS 5
`define ODSL_NUM_DACS 8
`define ODSL_DATA_BITS 8
`define ODSL_ADDR_BITS 3
`define ODSL_ADDR_MSB 14
`define ODSL_DATA_MSB 11
`define ODSL_CTRL_BIT 15
`define ODSL_BUF_BIT 2
`define ODSL_VDD_BIT 3
`define ODSL_QUAD_SEL_BIT 0
`define ODSL_REF_UNBUF 2'h0
`define ODSL_REF_BUF 2'h1
`define ODSL_REF_SUPPLY 2'h2
`endif

// File: src/odsl_sync.v
`timescale 1ns/1ns
// Two-stage synchroniser bank; the first stage feeds only the second.
module odsl_sync #(
  parameter WIDTH = 4
) (
  input wire i_clk,
  input wire i_rstn,
  input wire [WIDTH-1:0] i_async,
  output reg [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] meta_r;
  always @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      meta_r <= {WIDTH{1'b1}};
      o_sync <= {WIDTH{1'b1}};
    end
    else
    begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule

// File: src/odsl_top.v
// Functional notes
// - Low update strobe copies every input register into its DAC register.
// - One low strobe pulse updates all channels with new data together.
// - Strobe held low loads DAC registers continuously without pulses.
// - Frame select falling enables clock and data buffers and shifter.
// - One bit captured per falling serial clock edge, sixteen per frame.
// - Frame select rising before sixteenth edge aborts; nothing changes.
// - Shift register is exactly sixteen bits, shifting on falling clock.
// - After a complete write, input buffers power down until select falls.
// - Each quad picks buffered, unbuffered or supply reference from bits.
// - DAC register codes are unsigned straight binary.
`timescale 1ns/1ns
`include "odsl_consts.vh"
module odsl_top #(
  parameter DATA_BITS = `ODSL_DATA_BITS
) (
  input wire I_SYS_CLK,
  input wire I_RSTN,
  input wire I_FRAME_SEL_N,
  input wire I_SER_CLK,
  input wire I_SER_DATA,
  input wire I_OUTPUT_UPDATE_STROBE_N,
  output reg [`ODSL_NUM_DACS*DATA_BITS-1:0] O_DAC_CODES,
  output reg [`ODSL_NUM_DACS*DATA_BITS-1:0] O_INPUT_CODES,
  output reg O_INPUT_BUF_EN,
  output reg [3:0] O_QUAD_REF_MODE,
  output reg O_WORD_VALID,
  output reg O_FRAME_ABORT
);
  ////////////////////////////////////////////////////////////////////////////
  // Bench the serial clock far below the sampling clock; at the 30 MHz limit
  // a 25 MHz sampler would miss edges, which this block cannot detect.
  wire [3:0] sync_w;
  odsl_sync #(.WIDTH(4)) u_sync (
    .i_clk(I_SYS_CLK),
    .i_rstn(I_RSTN),
    .i_async({I_FRAME_SEL_N, I_SER_CLK, I_SER_DATA, I_OUTPUT_UPDATE_STROBE_N}),
    .o_sync(sync_w)
  );
  wire sel_n = sync_w[3];
  wire sclk = sync_w[2];
  wire sdin = sync_w[1];
  wire upd_n = sync_w[0];

  function [1:0] ref_mode;
    input buf_bit;
    input vdd_bit;
    begin
      if (vdd_bit)
        ref_mode = `ODSL_REF_SUPPLY;
      else if (buf_bit)
        ref_mode = `ODSL_REF_BUF;
      else
        ref_mode = `ODSL_REF_UNBUF;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  reg sel_n_d_r;
  reg sclk_d_r;
  reg active_r;
  reg [`ODSL_WORD_BITS-1:0] shift_r;
  reg [`ODSL_CNT_BITS-1:0] cnt_r;
  wire [`ODSL_NUM_DACS-1:0] wr_ch;
  integer k;
  wire sel_fall = sel_n_d_r & ~sel_n;
  wire sel_rise = ~sel_n_d_r & sel_n;
  wire sclk_fall = sclk_d_r & ~sclk;
  wire [`ODSL_WORD_BITS-1:0] shift_nxt = {shift_r[`ODSL_WORD_BITS-2:0], sdin};
  wire last_bit = (cnt_r == `ODSL_WORD_BITS - 1);
  wire take_bit = active_r & ~sel_n & sclk_fall;
  wire word_done = take_bit & last_bit;
  wire [`ODSL_ADDR_BITS-1:0] word_addr =
    shift_nxt[`ODSL_ADDR_MSB:`ODSL_ADDR_MSB-`ODSL_ADDR_BITS+1];
  wire [DATA_BITS-1:0] word_data = shift_nxt[`ODSL_DATA_MSB:`ODSL_DATA_MSB-DATA_BITS+1];
  wire is_ctrl = shift_nxt[`ODSL_CTRL_BIT];

  always @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
    begin
      sel_n_d_r <= 1'b1;
      sclk_d_r <= 1'b1;
      active_r <= 1'b0;
      shift_r <= {`ODSL_WORD_BITS{1'b0}};
      cnt_r <= {`ODSL_CNT_BITS{1'b0}};
      O_INPUT_BUF_EN <= 1'b0;
      O_WORD_VALID <= 1'b0;
      O_FRAME_ABORT <= 1'b0;
      O_QUAD_REF_MODE <= 4'h0;
    end
    else
    begin
      sel_n_d_r <= sel_n;
      sclk_d_r <= sclk;
      O_WORD_VALID <= word_done;
      O_FRAME_ABORT <= active_r & sel_rise;
      if (sel_fall)
      begin
        active_r <= 1'b1;
        O_INPUT_BUF_EN <= 1'b1;
        cnt_r <= {`ODSL_CNT_BITS{1'b0}};
      end
      else if (sel_rise | word_done)
      begin
        active_r <= 1'b0;
        O_INPUT_BUF_EN <= 1'b0;
        cnt_r <= {`ODSL_CNT_BITS{1'b0}};
      end
      else if (take_bit)
      begin
        shift_r <= shift_nxt;
        cnt_r <= cnt_r + 1'b1;
      end
      if (word_done & is_ctrl)
      begin
        if (shift_nxt[`ODSL_QUAD_SEL_BIT])
          O_QUAD_REF_MODE[3:2] <= ref_mode(shift_nxt[`ODSL_BUF_BIT],
            shift_nxt[`ODSL_VDD_BIT]);
        else
          O_QUAD_REF_MODE[1:0] <= ref_mode(shift_nxt[`ODSL_BUF_BIT],
            shift_nxt[`ODSL_VDD_BIT]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Input registers are written only by a complete word; DAC registers follow
  // when the strobe is low, so holding it low gives continuous update.
  // One process drives both code buses so that each has a single driver.
  genvar g;
  generate
    for (g = 0; g < `ODSL_NUM_DACS; g = g + 1)
    begin : g_ch
      assign wr_ch[g] = word_done & ~is_ctrl & (word_addr == g);
    end
  endgenerate

  always @(posedge I_SYS_CLK)
  begin
    if (!I_RSTN)
    begin
      O_INPUT_CODES <= {(`ODSL_NUM_DACS*DATA_BITS){1'b0}};
      O_DAC_CODES <= {(`ODSL_NUM_DACS*DATA_BITS){1'b0}};
    end
    else
    begin
      for (k = 0; k < `ODSL_NUM_DACS; k = k + 1)
      begin
        if (wr_ch[k])
          O_INPUT_CODES[k*DATA_BITS +: DATA_BITS] <= word_data;
        if (!upd_n)
          O_DAC_CODES[k*DATA_BITS +: DATA_BITS] <=
            O_INPUT_CODES[k*DATA_BITS +: DATA_BITS];
      end
    end
  end
endmodule

// File: sim/odsl_host.sv
`timescale 1ns/1ns
module odsl_host (
  output logic o_sel_n,
  output logic o_sclk,
  output logic o_sdata
);
  initial
  begin
    o_sel_n = 1'b1;
    o_sclk = 1'b1;
    o_sdata = 1'b0;
  end
  // The clock rests high between frames, at 320 ns, far below the limit.
  task send(input logic [15:0] w, input int n);
    o_sel_n = 1'b0;
    #320;
    for (int i = 15; i > 15 - n; i--)
    begin
      o_sdata = w[i];
      #160 o_sclk = 1'b0;
      #160 o_sclk = 1'b1;
    end
    o_sdata = ~o_sdata;
    #160 o_sel_n = 1'b1;
    #400;
  endtask
endmodule

// File: sim/odsl_monitor.sv
`timescale 1ns/1ns
`include "odsl_consts.vh"
module odsl_monitor #(parameter DATA_BITS = `ODSL_DATA_BITS) (
  input wire I_SYS_CLK,
  input wire I_RSTN,
  input wire I_FRAME_SEL_N,
  input wire I_OUTPUT_UPDATE_STROBE_N,
  input wire [`ODSL_NUM_DACS*DATA_BITS-1:0] O_DAC_CODES,
  input wire [`ODSL_NUM_DACS*DATA_BITS-1:0] O_INPUT_CODES,
  input wire O_INPUT_BUF_EN,
  input wire [3:0] O_QUAD_REF_MODE,
  input wire O_WORD_VALID,
  input wire O_FRAME_ABORT
);
  default clocking @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RSTN);
  // Four samples make sure the level has passed the synchroniser.
  sequence s_lo;
    !I_OUTPUT_UPDATE_STROBE_N[*4];
  endsequence
  property p_on;
    $fell(I_FRAME_SEL_N) |-> ##[1:5] O_INPUT_BUF_EN;
  endproperty
  a_on: assert property (p_on) else $error("buffers off");
  property p_off;
    O_WORD_VALID |-> !O_INPUT_BUF_EN;
  endproperty
  a_off: assert property (p_off) else $error("buffers on");
  property p_pulse;
    O_WORD_VALID |=> !O_WORD_VALID;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long valid");
  property p_abort;
    O_FRAME_ABORT |-> !O_WORD_VALID && $stable(O_INPUT_CODES);
  endproperty
  a_abort: assert property (p_abort) else $error("abort wrote");
  property p_copy;
    s_lo |=> O_DAC_CODES == $past(O_INPUT_CODES);
  endproperty
  a_copy: assert property (p_copy) else $error("no copy");
  property p_hold;
    I_OUTPUT_UPDATE_STROBE_N[*4] |=> $stable(O_DAC_CODES);
  endproperty
  a_hold: assert property (p_hold) else $error("dac moved");
  property p_quad;
    $changed(O_QUAD_REF_MODE) |-> O_WORD_VALID;
  endproperty
  a_quad: assert property (p_quad) else $error("quad moved");
  property p_inp;
    $changed(O_INPUT_CODES) |-> O_WORD_VALID;
  endproperty
  a_inp: assert property (p_inp) else $error("input moved");
endmodule
bind odsl_top odsl_monitor #(.DATA_BITS(DATA_BITS)) u_mon (.I_SYS_CLK(I_SYS_CLK),
  .I_RSTN(I_RSTN), .I_FRAME_SEL_N(I_FRAME_SEL_N), .O_DAC_CODES(O_DAC_CODES),
  .I_OUTPUT_UPDATE_STROBE_N(I_OUTPUT_UPDATE_STROBE_N), .O_INPUT_CODES(O_INPUT_CODES),
  .O_INPUT_BUF_EN(O_INPUT_BUF_EN), .O_QUAD_REF_MODE(O_QUAD_REF_MODE),
  .O_WORD_VALID(O_WORD_VALID), .O_FRAME_ABORT(O_FRAME_ABORT));

// File: sim/odsl_top_test.sv
`timescale 1ns/1ns
module odsl_top_test;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic stb_n = 1'b1;
  wire sel_n, sclk, sdat, buf_en, vld, abt;
  wire [63:0] dac, inp;
  wire [3:0] qref;
  int n_mismatch = 0;
  int checks_done = 0;
  int cyc = 0;
  always #20 clk = ~clk;
  odsl_host u_host (.o_sel_n(sel_n), .o_sclk(sclk), .o_sdata(sdat));
  odsl_top u_dut (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_FRAME_SEL_N(sel_n), .I_SER_CLK(sclk),
    .I_SER_DATA(sdat), .I_OUTPUT_UPDATE_STROBE_N(stb_n), .O_DAC_CODES(dac),
    .O_INPUT_CODES(inp), .O_INPUT_BUF_EN(buf_en), .O_QUAD_REF_MODE(qref),
    .O_WORD_VALID(vld), .O_FRAME_ABORT(abt));
  task check(input logic [63:0] s, input logic [63:0] e);
    checks_done++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task summarize;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      summarize();
    end
  end
  task t_pulse;
    u_host.send(16'h3A50, 16);
    check(inp[31:24], 8'hA5);
    check(dac, 64'h0);
    check(buf_en, 1'b0);
    @(negedge clk) stb_n = 1'b0;
    repeat (2) @(negedge clk);
    stb_n = 1'b1;
    repeat (4) @(negedge clk);
    check(dac[31:24], 8'hA5);
    $display("pulse update done");
  endtask
  task t_abort;
    u_host.send(16'h3C30, 12);
    check(inp[31:24], 8'hA5);
    $display("abort done");
  endtask
  task t_ref;
    u_host.send(16'h8009, 16);
    u_host.send(16'h8004, 16);
    check(qref, 4'h9);
    u_host.send(16'h8001, 16);
    check(qref, 4'h1);
    $display("reference modes done");
  endtask
  task t_held;
    @(negedge clk) stb_n = 1'b0;
    u_host.send(16'h07E0, 16);
    check(dac[7:0], 8'h7E);
    check(dac[31:24], 8'hA5);
    $display("held strobe done");
  endtask
  initial
  begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    t_pulse();
    t_abort();
    t_ref();
    t_held();
    summarize();
  end
endmodule
